// [logic/era_rx_alarm.sv]
// receive alarm detection, latched status and synchronizer status for an e1 receiver
// Overview of operation
// - latch tx store full on frame delete
// - latch tx store empty on frame repeat
// - latch jitter limit within four bits
// - latch rx store full and empty events
// - latch crc resync at 915 of 1000
// - latch fas resync after three bad words
// - latch cas resync after two bad words
// - six bit search counter, bit1 hidden
// - counter advances on each 8 ms timeout
// - counter clears on sync or mode off
// - counter wraps to zero after maximum
// - live fas, cas, crc search bits
// - sync status read-only, unlatched, no mask
// - signaling all ones over one multiframe
// - signaling all zeros over one multiframe
// - distant mf alarm, two multiframes each way
// - unframed all ones in 512-bit window
// - remote alarm, three occasions each way
// - carrier loss 255 zeros, 32 ones clear
// - loss of sync while framer unaligned
// - slip flag on rx frame repeat/delete
// - mask write captures and clears latched bits
// - masked alarms drive first interrupt output
`timescale 1ns/1ns
`default_nettype none

module era_latch_reg (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] set_evt,
    input wire logic wr_sel,
    input wire logic [7:0] wdata,
    output logic [7:0] read_reg,
    output logic [7:0] latch_reg
);
    // a set in the clearing cycle survives
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_reg <= era_pkg::REG_RESET;
            read_reg <= era_pkg::REG_RESET;
        end else begin
            for (int b = 0; b < 8; b++) begin
                if (wr_sel && wdata[b]) begin
                    read_reg[b] <= latch_reg[b] | set_evt[b];
                    latch_reg[b] <= set_evt[b];
                end else begin
                    latch_reg[b] <= latch_reg[b] | set_evt[b];
                end
            end
        end
    end
endmodule : era_latch_reg

module era_rx_alarm #(
    parameter int JA_CAPACITY = 128,
    parameter int JA_OCC_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic bit_valid,
    input wire logic bit_data,
    input wire logic in_ts16,
    input wire logic mf_end,
    input wire logic frame0_ts16_bit6,
    input wire logic nfas_bit3,
    input wire logic framer_in_sync,
    input wire logic fas_search,
    input wire logic cas_search,
    input wire logic crc_search,
    input wire logic crc_sync_achieved,
    input wire logic crc_search_timeout,
    input wire logic crc_mode_enable,
    input wire logic fas_word_error,
    input wire logic cas_word_error,
    input wire logic crc_word_done,
    input wire logic crc_word_error,
    input wire logic tx_store_full_evt,
    input wire logic tx_store_empty_evt,
    input wire logic rx_store_full_evt,
    input wire logic rx_store_empty_evt,
    input wire logic [JA_OCC_W-1:0] ja_occupancy,
    input wire logic [7:0] alarm_interrupt_mask,
    output logic interrupt_out_first,
    output logic [5:0] search_count
);
    if (JA_CAPACITY <= era_pkg::JA_MARGIN || JA_CAPACITY >= (1 << JA_OCC_W)) begin : g_bad_ja
        $error("jitter fifo capacity does not fit the occupancy width");
    end

    localparam logic [JA_OCC_W-1:0] JA_TRIP = JA_OCC_W'(JA_CAPACITY - era_pkg::JA_MARGIN);
    logic signaling_all_ones, signaling_all_zeros, distant_multiframe_alarm, unframed_all_ones;
    logic remote_alarm_flag, carrier_loss_flag, ts16_one_reg, dma_hist_reg, ts16_zero, ts16_one, crc_block_end;
    logic [1:0] ts16_zero_reg, rra_hist_reg, ua1_zero_reg, fas_err_reg, cas_err_reg;
    logic [8:0] ua1_pos_reg;
    logic [7:0] zero_run_reg, rcl_pos_reg, sr1_set, rir_set, sr1_read, sr1_latch, rir_read, rir_latch, ssr_live;
    logic [5:0] rcl_ones_reg, search_next;
    logic [9:0] crc_words_reg, crc_errs_reg, crc_errs_now;

    // timeslot 16 content checks per multiframe
    assign ts16_zero = bit_valid && in_ts16 && !bit_data;
    assign ts16_one = bit_valid && in_ts16 && bit_data;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ts16_zero_reg <= 2'h0;
            ts16_one_reg <= 1'b0;
            signaling_all_ones <= 1'b0;
            signaling_all_zeros <= 1'b0;
        end else if (mf_end) begin
            signaling_all_ones <= (ts16_zero_reg + 2'(ts16_zero && ts16_zero_reg != era_pkg::TS16_ZERO_MIN))
                < era_pkg::TS16_ZERO_MIN;
            signaling_all_zeros <= !(ts16_one_reg || ts16_one);
            ts16_zero_reg <= 2'h0;
            ts16_one_reg <= 1'b0;
        end else begin
            if (ts16_zero && ts16_zero_reg != era_pkg::TS16_ZERO_MIN) begin
                ts16_zero_reg <= ts16_zero_reg + 2'h1;
            end
            ts16_one_reg <= ts16_one_reg | ts16_one;
        end
    end

    // distant mf alarm and remote alarm histories
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dma_hist_reg <= 1'b0;
            distant_multiframe_alarm <= 1'b0;
        end else if (bit_valid && frame0_ts16_bit6) begin
            dma_hist_reg <= bit_data;
            if (dma_hist_reg && bit_data) begin
                distant_multiframe_alarm <= 1'b1;
            end else if (!dma_hist_reg && !bit_data) begin
                distant_multiframe_alarm <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rra_hist_reg <= 2'h0;
            remote_alarm_flag <= 1'b0;
        end else if (bit_valid && nfas_bit3) begin
            rra_hist_reg <= {rra_hist_reg[0], bit_data};
            if (rra_hist_reg == 2'h3 && bit_data) begin
                remote_alarm_flag <= 1'b1;
            end else if (rra_hist_reg == 2'h0 && !bit_data) begin
                remote_alarm_flag <= 1'b0;
            end
        end
    end

    // unframed all ones over two-frame windows
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ua1_pos_reg <= 9'h000;
            ua1_zero_reg <= 2'h0;
            unframed_all_ones <= 1'b0;
        end else if (bit_valid) begin
            ua1_pos_reg <= ua1_pos_reg + 9'h001;
            if (ua1_pos_reg == era_pkg::UA1_WINDOW_LAST) begin
                unframed_all_ones <= (ua1_zero_reg + 2'(!bit_data && ua1_zero_reg != era_pkg::UA1_ZERO_MIN))
                    < era_pkg::UA1_ZERO_MIN;
                ua1_zero_reg <= 2'h0;
            end else if (!bit_data && ua1_zero_reg != era_pkg::UA1_ZERO_MIN) begin
                ua1_zero_reg <= ua1_zero_reg + 2'h1;
            end
        end
    end

    // carrier loss: zero run sets, ones per 255-bit window clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            zero_run_reg <= 8'h00;
            rcl_pos_reg <= 8'h00;
            rcl_ones_reg <= 6'h00;
            carrier_loss_flag <= 1'b0;
        end else if (bit_valid) begin
            if (bit_data) begin
                zero_run_reg <= 8'h00;
            end else if (zero_run_reg != era_pkg::RCL_ZERO_RUN) begin
                zero_run_reg <= zero_run_reg + 8'h01;
            end
            if (rcl_pos_reg == era_pkg::RCL_WINDOW_LAST) begin
                rcl_pos_reg <= 8'h00;
                rcl_ones_reg <= 6'h00;
            end else begin
                rcl_pos_reg <= rcl_pos_reg + 8'h01;
                if (bit_data && rcl_ones_reg != era_pkg::RCL_ONES_MIN) begin
                    rcl_ones_reg <= rcl_ones_reg + 6'h01;
                end
            end
            if (!bit_data && zero_run_reg == era_pkg::RCL_ZERO_RUN - 8'h01) begin
                carrier_loss_flag <= 1'b1;
            end else if (rcl_pos_reg == era_pkg::RCL_WINDOW_LAST
                && (rcl_ones_reg + 6'(bit_data)) >= era_pkg::RCL_ONES_MIN) begin
                carrier_loss_flag <= 1'b0;
            end
        end
    end

    // resync criteria counters
    assign crc_block_end = crc_word_done && crc_words_reg == era_pkg::CRC_BLOCK_LAST;
    assign crc_errs_now = crc_errs_reg + 10'(crc_word_error);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_words_reg <= 10'h000;
            crc_errs_reg <= 10'h000;
        end else if (crc_word_done) begin
            crc_words_reg <= crc_block_end ? 10'h000 : crc_words_reg + 10'h001;
            crc_errs_reg <= crc_block_end ? 10'h000 : crc_errs_now;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fas_err_reg <= 2'h0;
            cas_err_reg <= 2'h0;
        end else begin
            if (fas_word_error) begin
                fas_err_reg <= (fas_err_reg == era_pkg::FAS_ERR_RUN - 2'h1) ? 2'h0 : fas_err_reg + 2'h1;
            end
            if (cas_word_error) begin
                cas_err_reg <= (cas_err_reg == era_pkg::CAS_ERR_RUN - 2'h1) ? 2'h0 : cas_err_reg + 2'h1;
            end
        end
    end

    // crc4 multiframe search counter
    always_comb begin
        search_next = search_count;
        if (crc_sync_achieved || !crc_mode_enable) begin
            search_next = era_pkg::SEARCH_ZERO;
        end else if (crc_search_timeout) begin
            search_next = search_count + era_pkg::SEARCH_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            search_count <= era_pkg::SEARCH_ZERO;
        end else begin
            search_count <= search_next;
        end
    end

    // event and level sources of both latched registers
    always_comb begin
        sr1_set = era_pkg::REG_RESET;
        sr1_set[era_pkg::SR1_SA1] = signaling_all_ones;
        sr1_set[era_pkg::SR1_DMA] = distant_multiframe_alarm;
        sr1_set[era_pkg::SR1_SA0] = signaling_all_zeros;
        sr1_set[era_pkg::SR1_SLIP] = rx_store_full_evt || rx_store_empty_evt;
        sr1_set[era_pkg::SR1_UA1] = unframed_all_ones;
        sr1_set[era_pkg::SR1_RRA] = remote_alarm_flag;
        sr1_set[era_pkg::SR1_RCL] = carrier_loss_flag;
        sr1_set[era_pkg::SR1_LOS] = !framer_in_sync;
        rir_set = era_pkg::REG_RESET;
        rir_set[era_pkg::RIR_TX_STORE_FULL_FLAG] = tx_store_full_evt;
        rir_set[era_pkg::RIR_TX_STORE_EMPTY_FLAG] = tx_store_empty_evt;
        rir_set[era_pkg::RIR_JITTER_FIFO_LIMIT_FLAG] = ja_occupancy >= JA_TRIP;
        rir_set[era_pkg::RIR_RX_STORE_FULL_FLAG] = rx_store_full_evt;
        rir_set[era_pkg::RIR_RX_STORE_EMPTY_FLAG] = rx_store_empty_evt;
        rir_set[era_pkg::RIR_CRC_RESYNC_CRITERIA] = crc_block_end && crc_errs_now >= era_pkg::CRC_ERR_MIN;
        rir_set[era_pkg::RIR_FRAME_ALIGN_RESYNC_CRITERIA] = fas_word_error && fas_err_reg == era_pkg::FAS_ERR_RUN - 2'h1;
        rir_set[era_pkg::RIR_SIGNALING_MF_RESYNC_CRITERIA] = cas_word_error && cas_err_reg == era_pkg::CAS_ERR_RUN - 2'h1;
    end

    era_latch_reg u_sr1 (
        .clk(clk), .rstn(rstn), .set_evt(sr1_set), .wr_sel(wr_en && addr == era_pkg::ADDR_ALARM_STATUS),
        .wdata(wdata), .read_reg(sr1_read), .latch_reg(sr1_latch)
    );

    era_latch_reg u_rir (
        .clk(clk), .rstn(rstn), .set_evt(rir_set), .wr_sel(wr_en && addr == era_pkg::ADDR_RX_INFO),
        .wdata(wdata), .read_reg(rir_read), .latch_reg(rir_latch)
    );

    assign ssr_live = {search_count[5:2], search_count[0], fas_search, cas_search, crc_search};
    assign interrupt_out_first = |(sr1_latch & alarm_interrupt_mask);

    // register read port
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= era_pkg::REG_RESET;
        end else if (rd_en) begin
            case (addr)
                era_pkg::ADDR_ALARM_STATUS: rdata <= sr1_read;
                era_pkg::ADDR_RX_INFO: rdata <= rir_read;
                era_pkg::ADDR_SYNC_STATUS: rdata <= ssr_live;
                default: rdata <= era_pkg::REG_RESET;
            endcase
        end
    end

    sequence s_mask_write(logic [7:0] a, int b);
        wr_en && addr == a && wdata[b];
    endsequence

    tx_full_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        tx_store_full_evt |=> rir_latch[era_pkg::RIR_TX_STORE_FULL_FLAG])
        else $error("tx store full not latched");
    tx_empty_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        tx_store_empty_evt |=> rir_latch[era_pkg::RIR_TX_STORE_EMPTY_FLAG])
        else $error("tx store empty not latched");
    ja_limit_a: assert property (@(posedge clk) disable iff (!rstn)
        ja_occupancy >= JA_TRIP |=> rir_latch[era_pkg::RIR_JITTER_FIFO_LIMIT_FLAG])
        else $error("jitter limit not latched");
    rx_store_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        rx_store_full_evt |=> rir_latch[era_pkg::RIR_RX_STORE_FULL_FLAG] && sr1_latch[era_pkg::SR1_SLIP])
        else $error("rx store full not latched");
    fas_resync_a: assert property (@(posedge clk) disable iff (!rstn)
        fas_word_error && fas_err_reg == era_pkg::FAS_ERR_RUN - 2'h1 |=> rir_latch[era_pkg::RIR_FRAME_ALIGN_RESYNC_CRITERIA])
        else $error("fas resync not latched");
    search_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        !crc_mode_enable |=> search_count == era_pkg::SEARCH_ZERO)
        else $error("search counter not cleared");
    search_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
        crc_search_timeout && crc_mode_enable && !crc_sync_achieved
        |=> search_count == $past(search_count) + era_pkg::SEARCH_ONE)
        else $error("search counter step wrong");
    carrier_loss_a: assert property (@(posedge clk) disable iff (!rstn)
        bit_valid && !bit_data && zero_run_reg == era_pkg::RCL_ZERO_RUN - 8'h01 |=> carrier_loss_flag)
        else $error("carrier loss not set");
    mask_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        s_mask_write(era_pkg::ADDR_ALARM_STATUS, era_pkg::SR1_LOS) ##0 !framer_in_sync
        ##1 rd_en && addr == era_pkg::ADDR_ALARM_STATUS |=> rdata[era_pkg::SR1_LOS])
        else $error("captured status not returned");
    ssr_live_a: assert property (@(posedge clk) disable iff (!rstn)
        rd_en && addr == era_pkg::ADDR_SYNC_STATUS |=> rdata == $past(ssr_live))
        else $error("sync status read wrong");
endmodule : era_rx_alarm
`default_nettype wire

// [logic/era_pkg.sv]
// constants for the receive alarm and synchronizer status block
package era_pkg;
    localparam logic [7:0] ADDR_ALARM_STATUS = 8'h06;
    localparam logic [7:0] ADDR_RX_INFO = 8'h08;
    localparam logic [7:0] ADDR_SYNC_STATUS = 8'h1E;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SR1_SA1 = 7;
    localparam int SR1_DMA = 6;
    localparam int SR1_SA0 = 5;
    localparam int SR1_SLIP = 4;
    localparam int SR1_UA1 = 3;
    localparam int SR1_RRA = 2;
    localparam int SR1_RCL = 1;
    localparam int SR1_LOS = 0;
    localparam int RIR_TX_STORE_FULL_FLAG = 7;
    localparam int RIR_TX_STORE_EMPTY_FLAG = 6;
    localparam int RIR_JITTER_FIFO_LIMIT_FLAG = 5;
    localparam int RIR_RX_STORE_FULL_FLAG = 4;
    localparam int RIR_RX_STORE_EMPTY_FLAG = 3;
    localparam int RIR_CRC_RESYNC_CRITERIA = 2;
    localparam int RIR_FRAME_ALIGN_RESYNC_CRITERIA = 1;
    localparam int RIR_SIGNALING_MF_RESYNC_CRITERIA = 0;
    localparam logic [1:0] TS16_ZERO_MIN = 2'h3;
    localparam logic [1:0] UA1_ZERO_MIN = 2'h3;
    localparam logic [8:0] UA1_WINDOW_LAST = 9'h1FF;
    localparam logic [7:0] RCL_ZERO_RUN = 8'hFF;
    localparam logic [7:0] RCL_WINDOW_LAST = 8'hFE;
    localparam logic [5:0] RCL_ONES_MIN = 6'h20;
    localparam logic [9:0] CRC_BLOCK_LAST = 10'h3E7;
    localparam logic [9:0] CRC_ERR_MIN = 10'h393;
    localparam logic [1:0] FAS_ERR_RUN = 2'h3;
    localparam logic [1:0] CAS_ERR_RUN = 2'h2;
    localparam logic [5:0] SEARCH_ZERO = 6'h00;
    localparam logic [5:0] SEARCH_ONE = 6'h01;
    localparam int JA_MARGIN = 4;
endpackage : era_pkg

// [sim/era_line_model.sv]
// line side model: receive bit stream with frame and multiframe position strobes
`timescale 1ns/1ns
`default_nettype none
module era_line_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic level,
    output logic bit_valid,
    output logic bit_data,
    output logic in_ts16,
    output logic mf_end,
    output logic frame0_ts16_bit6,
    output logic nfas_bit3
);
    logic [11:0] pos_reg;
    logic tog_reg;
    // bit position inside a 16 frame multiframe of 256 bits per frame
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_reg <= 12'h000;
            tog_reg <= 1'b0;
        end else begin
            tog_reg <= ~tog_reg;
            if (run) begin
                pos_reg <= pos_reg + 12'h001;
            end
        end
    end
    // idle line toggles so a stale level is never seen
    assign bit_valid = run;
    assign bit_data = run ? level : tog_reg;
    assign in_ts16 = run && (pos_reg[7:3] == 5'h10);
    assign mf_end = run && (pos_reg == 12'hFFF);
    assign frame0_ts16_bit6 = run && (pos_reg == 12'h085);
    assign nfas_bit3 = run && pos_reg[8] && (pos_reg[7:0] == 8'h02);
endmodule : era_line_model
`default_nettype wire

// [sim/e1_rx_alarm_sync_status_tb_top.sv]
// self-checking bench for the receive alarm and synchronizer status block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module e1_rx_alarm_sync_status_tb_top;
    localparam logic [7:0] A_SR = era_pkg::ADDR_ALARM_STATUS;
    localparam logic [7:0] A_RI = era_pkg::ADDR_RX_INFO;
    localparam logic [7:0] A_SS = era_pkg::ADDR_SYNC_STATUS;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sync_in = 1'b1;
    logic mode_en = 1'b1;
    logic run = 1'b0;
    logic level = 1'b0;
    logic [2:0] hunt = 3'h0;
    logic [9:0] pls = 10'h000;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] irq_mask = 8'h00;
    logic [7:0] ja_occ = 8'h00;
    logic [7:0] rdata, e_v, c_v;
    logic [5:0] scount, cnt;
    logic irq, bv, bd, ts16, mfe, f0b6, nb3;
    logic [1:0] rd_q = 2'h0;
    logic [31:0] seed = 32'h0000002E;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] exp_q[$];
    logic [7:0] care_q[$];
    string name_q[$];
    string n_v;

    always #2 clk = ~clk;

    era_line_model LINE (.clk(clk), .rstn(rstn), .run(run), .level(level), .bit_valid(bv), .bit_data(bd),
        .in_ts16(ts16), .mf_end(mfe), .frame0_ts16_bit6(f0b6), .nfas_bit3(nb3));

    era_rx_alarm #(.JA_CAPACITY(128), .JA_OCC_W(8)) DUT (
        .clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
        .bit_valid(bv), .bit_data(bd), .in_ts16(ts16), .mf_end(mfe), .frame0_ts16_bit6(f0b6),
        .nfas_bit3(nb3), .framer_in_sync(sync_in), .fas_search(hunt[2]), .cas_search(hunt[1]),
        .crc_search(hunt[0]), .crc_sync_achieved(pls[9]), .crc_search_timeout(pls[8]),
        .crc_mode_enable(mode_en), .fas_word_error(pls[4]), .cas_word_error(pls[5]),
        .crc_word_done(pls[6]), .crc_word_error(pls[7]), .tx_store_full_evt(pls[0]),
        .tx_store_empty_evt(pls[1]), .rx_store_full_evt(pls[2]), .rx_store_empty_evt(pls[3]),
        .ja_occupancy(ja_occ), .alarm_interrupt_mask(irq_mask), .interrupt_out_first(irq),
        .search_count(scount));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic pulse(input logic [9:0] p);
        @(negedge clk) pls = p;
        @(negedge clk) pls = 10'h000;
    endtask : pulse

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) begin
            addr = a;
            wdata = d;
            wr_en = 1'b1;
        end
        @(negedge clk) wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] c, input string nm);
        exp_q.push_back(e);
        care_q.push_back(c);
        name_q.push_back(nm);
        @(negedge clk) begin
            addr = a;
            rd_en = 1'b1;
        end
        @(negedge clk) rd_en = 1'b0;
        @(negedge clk);
    endtask : rd

    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input logic [7:0] c,
        input string nm);
        wr(a, m);
        rd(a, e, c, nm);
        wr(a, e & m);
    endtask : poll

    task automatic irqchk(input logic [7:0] m, input logic e);
        @(negedge clk) irq_mask = m;
        #1 `CHK("interrupt", e, irq)
    endtask : irqchk

    // read monitor: compare settled read data with the oldest note
    always @(posedge clk) rd_q <= {rd_q[0], rd_en};
    always @(negedge clk) begin
        if (rd_q[1]) begin
            e_v = exp_q.pop_front();
            c_v = care_q.pop_front();
            n_v = name_q.pop_front();
            `CHK(n_v, (e_v & c_v), (rdata & c_v))
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        rd(A_SR, 8'h00, 8'hFF, "alarm_status");
        rd(A_RI, 8'h00, 8'hFF, "rx_info");
        rd(A_SS, 8'h00, 8'hFF, "sync_status");
        rd(8'h10, 8'h00, 8'hFF, "unmapped");
        pulse(10'h00F);
        wr(A_RI, 8'h80);
        rd(A_RI, 8'h80, 8'hFF, "rx_info");
        wr(A_RI, 8'h58);
        rd(A_RI, 8'hD8, 8'hFF, "rx_info");
        wr(A_RI, 8'h80);
        rd(A_RI, 8'h58, 8'hFF, "rx_info");
        poll(A_RI, 8'hFF, 8'h00, 8'hFF, "rx_info");
        irqchk(8'h10, 1'b1);
        irqchk(8'hEF, 1'b0);
        poll(A_SR, 8'hFF, 8'h10, 8'hFF, "alarm_status");
        irqchk(8'hFF, 1'b0);
        ja_occ = 8'h7B;
        poll(A_RI, 8'hFF, 8'h00, 8'hFF, "jitter_limit");
        ja_occ = 8'h7C;
        poll(A_RI, 8'hFF, 8'h20, 8'hFF, "jitter_limit");
        ja_occ = 8'h00;
        wr(A_RI, 8'hFF);
        poll(A_RI, 8'hFF, 8'h00, 8'hFF, "jitter_limit");
        repeat (2) pulse(10'h010);
        pulse(10'h020);
        poll(A_RI, 8'hFF, 8'h00, 8'hFF, "resync");
        pulse(10'h030);
        poll(A_RI, 8'hFF, 8'h03, 8'hFF, "resync");
        for (int k = 914; k < 916; k++) begin
            for (int i = 0; i < 1000; i++) pulse((i < k) ? 10'h0C0 : 10'h040);
            poll(A_RI, 8'hFF, (k == 915) ? 8'h04 : 8'h00, 8'hFF, "crc_resync");
        end
        cnt = 6'h00;
        for (int i = 0; i < 64; i++) begin
            pulse(10'h100);
            cnt = cnt + 6'h01;
            `CHK("search_count", cnt, scount)
        end
        for (int j = 0; j < 4; j++) begin
            seed = xs(seed);
            repeat (seed[3:0]) pulse(10'h100);
            cnt = cnt + {2'h0, seed[3:0]};
            hunt = seed[6:4];
            rd(A_SS, {cnt[5:2], cnt[0], seed[6:4]}, 8'hFF, "sync_status");
        end
        pulse(10'h300);
        `CHK("search_count", 6'h00, scount)
        repeat (5) pulse(10'h100);
        mode_en = 1'b0;
        @(negedge clk);
        `CHK("search_count", 6'h00, scount)
        mode_en = 1'b1;
        hunt = 3'h0;
        sync_in = 1'b0;
        level = 1'b1;
        run = 1'b1;
        repeat (8192) @(negedge clk);
        run = 1'b0;
        poll(A_SR, 8'hFF, 8'hCD, 8'hFF, "alarm_status");
        level = 1'b0;
        run = 1'b1;
        repeat (8192) @(negedge clk);
        run = 1'b0;
        poll(A_SR, 8'hFF, 8'hEF, 8'hFF, "alarm_status");
        poll(A_SR, 8'hFF, 8'h23, 8'hFF, "alarm_status");
        irqchk(8'h02, 1'b1);
        irqchk(8'h80, 1'b0);
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule : e1_rx_alarm_sync_status_tb_top
`default_nettype wire
